// ==== hapm_pkg.sv ====
// Purpose: shared constants and carriers for the high address pin mux
// Assumes: 8-bit register port, one clock, synchronous reset
// Notes: register offsets and layouts below are local choices
package hapm_pkg;
	// register offsets
	localparam logic [3:0] ADDR_HACTL = 4'h0;
	localparam logic [3:0] ADDR_PDATA = 4'h1;
	localparam logic [3:0] ADDR_PDIR = 4'h2;
	localparam logic [3:0] ADDR_PULLUP = 4'h3;
	localparam logic [3:0] ADDR_MODE = 4'h4;
	localparam logic [3:0] ADDR_PIN = 4'h5;
	// field positions in the port 2 style registers
	localparam int BIT_PORT1_BIT7 = 6;
	localparam int NUM_PINS = 7;
	// reset values: single-chip mode with HACTL selecting address use, pins input, no pull-ups
	localparam logic [7:0] RST_HACTL = 8'h00;
	localparam logic [7:0] RST_PDATA = 8'h00;
	localparam logic [7:0] RST_PDIR = 8'h00;
	localparam logic [7:0] RST_PULLUP = 8'h00;
	localparam logic [7:0] RST_MODE = 8'h00;
	// per pin drive carrier
	typedef struct packed {
		logic out;
		logic oe_n;
		logic pull;
	} hapm_pin_t;
	// bus request carrier
	typedef struct packed {
		logic [3:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} hapm_req_t;
endpackage

// ==== hapm_sync.sv ====
// Purpose: two-flop synchroniser for a group of pin inputs
// Assumes: one clock
// Notes: first stage feeds only the second stage
`timescale 1ns/1ps
`default_nettype none
module hapm_sync #(
	parameter int W = 7
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// data
	input wire logic [W-1:0] async_in,
	output logic [W-1:0] sync_out
);
	logic [W-1:0] meta_q;
	// two stages, reset to zero
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			meta_q <= '0;
			sync_out <= '0;
		end
		else
		begin
			meta_q <= async_in;
			sync_out <= meta_q;
		end
	end
endmodule // hapm_sync
`default_nettype wire

// ==== hapm_top.sv ====
// Purpose: pin mux for upper address pins and address/data bit 15
// Assumes: pad cells resolve out/oe_n/pull; oe_n low drives the pin
// Notes: pins 0..5 are port 2 bits 0..5, pin 6 is port 1 bit 7
`timescale 1ns/1ps
`default_nettype none
module hapm_top (
	// clock and reset
	input wire logic CORE_CLK,
	input wire logic RESET,
	// register port
	input wire logic [3:0] REG_ADDR,
	input wire logic [7:0] REG_WDATA,
	input wire logic REG_WR,
	input wire logic REG_RD,
	output logic [7:0] REG_RDATA,
	// external bus core side
	input wire logic [21:16] HIGH_ADDR,
	input wire logic MUXED_ADDR_DATA_BIT15_OUT,
	input wire logic MUXED_ADDR_DATA_BIT15_OE,
	output logic MUXED_ADDR_DATA_BIT15_IN,
	// pads: port2 bits 0..5 then port1 bit 7
	input wire logic [6:0] PIN_IN,
	output logic [6:0] PIN_OUT,
	output logic [6:0] PIN_OE_N,
	output logic [6:0] PIN_PULL,
	// peripheral taps
	output logic CAPTURE0_SAMPLE_IN,
	output logic CAPTURE1_SAMPLE_IN
);
	logic [7:0] hactl_q, pdata_q, pdir_q, pull_q, mode_q;
	logic [7:0] rdata_d;
	logic [6:0] pin_s;
	logic ext_bus;
	logic [6:0] addr_sel;
	logic [6:0] addr_val;
	hapm_pkg::hapm_req_t req;
	hapm_pkg::hapm_pin_t pin_d [hapm_pkg::NUM_PINS];
	assign req = '{addr: REG_ADDR, wdata: REG_WDATA, wr: REG_WR, rd: REG_RD};
	// mode bit 0 set means external bus mode, clear single-chip
	assign ext_bus = mode_q[0];
	// pad inputs come from outside the clock domain
	hapm_sync #(.W(7)) u_sync (
		.clk(CORE_CLK),
		.rst(RESET),
		.async_in(PIN_IN),
		.sync_out(pin_s)
	);
	// register writes
	always_ff @(posedge CORE_CLK)
	begin
		if (RESET)
		begin
			hactl_q <= hapm_pkg::RST_HACTL;
			pdata_q <= hapm_pkg::RST_PDATA;
			pdir_q <= hapm_pkg::RST_PDIR;
			pull_q <= hapm_pkg::RST_PULLUP;
			mode_q <= hapm_pkg::RST_MODE;
		end
		else if (req.wr)
		begin
			case (req.addr)
				hapm_pkg::ADDR_HACTL: hactl_q <= {2'h0, req.wdata[5:0]};
				hapm_pkg::ADDR_PDATA: pdata_q <= {1'b0, req.wdata[6:0]};
				hapm_pkg::ADDR_PDIR: pdir_q <= {1'b0, req.wdata[6:0]};
				hapm_pkg::ADDR_PULLUP: pull_q <= {1'b0, req.wdata[6:0]};
				hapm_pkg::ADDR_MODE: mode_q <= {7'h00, req.wdata[0]};
				default: ;
			endcase
		end
	end
	// read decode; unmapped reads return zero
	assign rdata_d = !req.rd ? 8'h00 :
		(req.addr == hapm_pkg::ADDR_HACTL) ? hactl_q :
		(req.addr == hapm_pkg::ADDR_PDATA) ? pdata_q :
		(req.addr == hapm_pkg::ADDR_PDIR) ? pdir_q :
		(req.addr == hapm_pkg::ADDR_PULLUP) ? pull_q :
		(req.addr == hapm_pkg::ADDR_MODE) ? mode_q :
		(req.addr == hapm_pkg::ADDR_PIN) ? {1'b0, pin_s} : 8'h00;
	assign addr_sel[5:0] = ext_bus ? ~hactl_q[5:0] : 6'h00;
	// port 1 bit 7 is bus pin whenever the bus is on
	assign addr_sel[6] = ext_bus;
	assign addr_val = {MUXED_ADDR_DATA_BIT15_OUT, HIGH_ADDR[21:16]};
	// per pin mux, same structure for every pin
	generate
		for (genvar i = 0; i < hapm_pkg::NUM_PINS; i++)
		begin : g_pin
			// address use overrides port driver and pull-up
			// pull-up only on a port pin set as input
			// bit 15 drive follows the core direction
			assign pin_d[i].out = addr_sel[i] ? addr_val[i] : pdata_q[i];
			assign pin_d[i].oe_n = !addr_sel[i] ? ~pdir_q[i] :
				(i == hapm_pkg::BIT_PORT1_BIT7) ? ~MUXED_ADDR_DATA_BIT15_OE : 1'b0;
			assign pin_d[i].pull = addr_sel[i] ? 1'b0 : (pull_q[i] & ~pdir_q[i]);
			// registered pad drive
			always_ff @(posedge CORE_CLK)
			begin
				if (RESET)
				begin
					PIN_OUT[i] <= 1'b0;
					PIN_OE_N[i] <= 1'b1;
					PIN_PULL[i] <= 1'b0;
				end
				else
				begin
					PIN_OUT[i] <= pin_d[i].out;
					PIN_OE_N[i] <= pin_d[i].oe_n;
					PIN_PULL[i] <= pin_d[i].pull;
				end
			end
		end
	endgenerate
	// read data, capture taps and bus input registered
	always_ff @(posedge CORE_CLK)
	begin
		if (RESET)
		begin
			REG_RDATA <= 8'h00;
			CAPTURE0_SAMPLE_IN <= 1'b0;
			CAPTURE1_SAMPLE_IN <= 1'b0;
			MUXED_ADDR_DATA_BIT15_IN <= 1'b0;
		end
		else
		begin
			REG_RDATA <= rdata_d;
			// capture taps see the pin in every mode
			CAPTURE0_SAMPLE_IN <= pin_s[4];
			CAPTURE1_SAMPLE_IN <= pin_s[5];
			MUXED_ADDR_DATA_BIT15_IN <= pin_s[hapm_pkg::BIT_PORT1_BIT7];
		end
	end
	// checks
	a_addr_pin_drive: assert property (@(posedge CORE_CLK) disable iff (RESET)
		(ext_bus && !hactl_q[0]) |=> (PIN_OUT[0] == $past(HIGH_ADDR[16]) && !PIN_OE_N[0]))
		else $error("address bit 16 not driven");
	a_port_pin_drive: assert property (@(posedge CORE_CLK) disable iff (RESET)
		(ext_bus && hactl_q[1]) |=> (PIN_OUT[1] == $past(pdata_q[1])))
		else $error("port bit 1 not port data");
	a_bit20_drive: assert property (@(posedge CORE_CLK) disable iff (RESET)
		(ext_bus && !hactl_q[4]) |=> (PIN_OUT[4] == $past(HIGH_ADDR[20])))
		else $error("address bit 20 not driven");
	a_bit21_drive: assert property (@(posedge CORE_CLK) disable iff (RESET)
		(ext_bus && !hactl_q[5]) |=> (PIN_OUT[5] == $past(HIGH_ADDR[21])))
		else $error("address bit 21 not driven");
	a_p5_port: assert property (@(posedge CORE_CLK) disable iff (RESET)
		(ext_bus && hactl_q[5]) |=> (PIN_OE_N[5] == !$past(pdir_q[5])))
		else $error("port bit 5 direction wrong");
	a_single_chip: assert property (@(posedge CORE_CLK) disable iff (RESET)
		!ext_bus |=> (PIN_OUT[6] == $past(pdata_q[6])))
		else $error("bit 7 not port in single chip");
	a_bus15_dir: assert property (@(posedge CORE_CLK) disable iff (RESET)
		ext_bus |=> (PIN_OE_N[6] == !$past(MUXED_ADDR_DATA_BIT15_OE)))
		else $error("bus bit 15 direction wrong");
	a_pull_ctrl: assert property (@(posedge CORE_CLK) disable iff (RESET)
		(!ext_bus && pull_q[2] && !pdir_q[2]) |=> PIN_PULL[2])
		else $error("pull-up not applied");
	a_pull_ignored: assert property (@(posedge CORE_CLK) disable iff (RESET)
		(ext_bus && !hactl_q[3]) |=> !PIN_PULL[3])
		else $error("pull-up on address pin");
	a_capture_tap: assert property (@(posedge CORE_CLK) disable iff (RESET)
		1'b1 |=> (CAPTURE0_SAMPLE_IN == $past(pin_s[4])))
		else $error("capture 0 tap wrong");
	// address pin checks, one per high address bit 17 to 21
	a_bit17_drive: assert property (@(posedge CORE_CLK) disable iff (RESET)
		(ext_bus && !hactl_q[1]) |=> (PIN_OUT[1] == $past(HIGH_ADDR[17]) && !PIN_OE_N[1]))
		else $error("address bit 17 not driven");
	a_bit18_drive: assert property (@(posedge CORE_CLK) disable iff (RESET)
		(ext_bus && !hactl_q[2]) |=> (PIN_OUT[2] == $past(HIGH_ADDR[18]) && !PIN_OE_N[2]))
		else $error("address bit 18 not driven");
	a_bit19_drive: assert property (@(posedge CORE_CLK) disable iff (RESET)
		(ext_bus && !hactl_q[3]) |=> (PIN_OUT[3] == $past(HIGH_ADDR[19]) && !PIN_OE_N[3]))
		else $error("address bit 19 not driven");
	a_bit20_enable: assert property (@(posedge CORE_CLK) disable iff (RESET)
		(ext_bus && !hactl_q[4]) |=> !PIN_OE_N[4])
		else $error("address bit 20 not enabled");
	a_bit21_enable: assert property (@(posedge CORE_CLK) disable iff (RESET)
		(ext_bus && !hactl_q[5]) |=> !PIN_OE_N[5])
		else $error("address bit 21 not enabled");
	// port and pull-up checks
	a_p0_port: assert property (@(posedge CORE_CLK) disable iff (RESET)
		(ext_bus && hactl_q[0]) |=> (PIN_OE_N[0] == !$past(pdir_q[0])))
		else $error("port bit 0 direction wrong");
	a_p4_port: assert property (@(posedge CORE_CLK) disable iff (RESET)
		(ext_bus && hactl_q[4]) |=> (PIN_OUT[4] == $past(pdata_q[4])))
		else $error("port bit 4 not port data");
	a_single_dir: assert property (@(posedge CORE_CLK) disable iff (RESET)
		!ext_bus |=> (PIN_OE_N[6] == !$past(pdir_q[6])))
		else $error("bit 7 direction wrong in single chip");
	a_pull_output: assert property (@(posedge CORE_CLK) disable iff (RESET)
		pdir_q[2] |=> !PIN_PULL[2])
		else $error("pull-up on output pin");
	a_single_pull: assert property (@(posedge CORE_CLK) disable iff (RESET)
		(!ext_bus && !pull_q[6]) |=> !PIN_PULL[6])
		else $error("pull-up applied while off");
	a_bus_no_pull: assert property (@(posedge CORE_CLK) disable iff (RESET)
		ext_bus |=> !PIN_PULL[6])
		else $error("pull-up on bus bit 15");
	// bit 15 and tap checks
	a_bus15_out: assert property (@(posedge CORE_CLK) disable iff (RESET)
		ext_bus |=> (PIN_OUT[6] == $past(MUXED_ADDR_DATA_BIT15_OUT)))
		else $error("bus bit 15 out wrong");
	a_bus15_in: assert property (@(posedge CORE_CLK) disable iff (RESET)
		1'b1 |=> (MUXED_ADDR_DATA_BIT15_IN == $past(pin_s[6])))
		else $error("bus bit 15 in wrong");
	a_capture1_tap: assert property (@(posedge CORE_CLK) disable iff (RESET)
		1'b1 |=> (CAPTURE1_SAMPLE_IN == $past(pin_s[5])))
		else $error("capture 1 tap wrong");
endmodule // hapm_top
`default_nettype wire

// ==== hapm_ext_mem.sv ====
// Purpose: far side and pad model for the pin mux
// Assumes: bench picks which pins the far side drives
// Notes: a floating pin shows the inverse of the last out
`timescale 1ns/1ps
`default_nettype none
module hapm_ext_mem (
	// pads
	input wire logic [6:0] pin_out,
	input wire logic [6:0] pin_oe_n,
	input wire logic [6:0] pin_pull,
	// far side drive
	input wire logic [6:0] ext_en,
	input wire logic [6:0] ext_val,
	output logic [6:0] pin_lvl
);
	// pad level resolution
	// no lucky settled value on a floating line
	always_comb
	begin
		for (int i = 0; i < 7; i++)
		begin
			pin_lvl[i] = !pin_oe_n[i] ? pin_out[i] : ext_en[i] ? ext_val[i] :
				pin_pull[i] ? 1'h1 : ~pin_out[i];
		end
	end
endmodule // hapm_ext_mem
`default_nettype wire

// ==== hapm_top_tb.sv ====
// Purpose: self-checking bench for the pin mux
// Assumes: 4 ns clock, pins settle within 4 edges
// Notes: far side model resolves the pads
`timescale 1ns/1ps
`default_nettype none
module hapm_top_tb;
	logic clk = 1'h0;
	logic rst = 1'h1;
	logic [3:0] a = 4'h0;
	logic [7:0] wd = 8'h00;
	logic wr = 1'h0;
	logic rd = 1'h0;
	logic [7:0] rdat;
	logic [21:16] ha = 6'h00;
	logic ado = 1'h0;
	logic adoe = 1'h0;
	logic adi, c0, c1;
	logic [6:0] pi, po, pn, pp;
	logic [6:0] xe = 7'h00;
	logic [6:0] xv = 7'h00;
	int n_errors = 0;
	int num_checks = 0;
	hapm_top i_dut (.CORE_CLK(clk), .RESET(rst), .REG_ADDR(a), .REG_WDATA(wd), .REG_WR(wr),
		.REG_RD(rd), .REG_RDATA(rdat), .HIGH_ADDR(ha), .MUXED_ADDR_DATA_BIT15_OUT(ado),
		.MUXED_ADDR_DATA_BIT15_OE(adoe), .MUXED_ADDR_DATA_BIT15_IN(adi), .PIN_IN(pi),
		.PIN_OUT(po), .PIN_OE_N(pn), .PIN_PULL(pp),
		.CAPTURE0_SAMPLE_IN(c0), .CAPTURE1_SAMPLE_IN(c1));
	hapm_ext_mem i_ext (.pin_out(po), .pin_oe_n(pn), .pin_pull(pp), .ext_en(xe),
		.ext_val(xv), .pin_lvl(pi));
	// clock
	initial
	begin
		forever #2 clk = ~clk;
	end
	task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
		num_checks++;
		if (s !== e)
		begin
			n_errors++;
			$display("MISMATCH %s exp %h seen %h", n, e, s);
		end
	endtask
	task automatic wreg(input logic [3:0] ad, input logic [7:0] d);
		@(posedge clk);
		a <= ad;
		wd <= d;
		wr <= 1'h1;
		@(posedge clk);
		wr <= 1'h0;
	endtask
	task automatic rreg(input logic [3:0] ad, input logic [7:0] e);
		@(posedge clk);
		a <= ad;
		rd <= 1'h1;
		@(posedge clk);
		rd <= 1'h0;
		#1 chk("rdata", rdat, e);
	endtask
	// covers the two sync flops and the output flop
	task automatic settle();
		repeat (4) @(posedge clk);
		#1;
	endtask
	task automatic close_out();
		if (n_errors == 0 && num_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	// hang guard, tests need under 200 cycles
	initial
	begin
		#4000;
		n_errors++;
		close_out();
	end
	// main sequence
	initial
	begin
		repeat (6) @(posedge clk);
		rst <= 1'h0;
		for (int i = 0; i < 5; i++)
			rreg(i[3:0], 8'h00);
		chk("oe_n", {1'h0, pn}, 8'h7F);
		wreg(4'hF, 8'hFF);
		rreg(4'hF, 8'h00);
		// bus mode, address on 1 3 5, inputs with pull-ups on 0 2 4
		wreg(hapm_pkg::ADDR_MODE, 8'h01);
		wreg(hapm_pkg::ADDR_PDATA, 8'h3F);
		wreg(hapm_pkg::ADDR_PULLUP, 8'h3F);
		wreg(hapm_pkg::ADDR_HACTL, 8'h15);
		xe <= 7'h10;
		settle();
		chk("oe_n", {2'h0, pn[5:0]}, 8'h15);
		chk("addr", {2'h0, po[5:0] & ~pn[5:0]}, 8'h00);
		chk("pull", {2'h0, pp[5:0]}, 8'h15);
		chk("cap", {6'h00, c1, c0}, 8'h00);
		// address on 0 2 4, port outputs on 1 3 5
		@(posedge clk);
		ha <= 6'h15;
		wreg(hapm_pkg::ADDR_PDIR, 8'h3F);
		wreg(hapm_pkg::ADDR_PDATA, 8'h00);
		wreg(hapm_pkg::ADDR_HACTL, 8'h2A);
		rreg(hapm_pkg::ADDR_HACTL, 8'h2A);
		settle();
		chk("out", {2'h0, po[5:0]}, 8'h15);
		chk("oe_n", {2'h0, pn[5:0]}, 8'h00);
		chk("cap", {6'h00, c1, c0}, 8'h01);
		// bit 15 driven by the core, then by the far side
		@(posedge clk);
		ado <= 1'h1;
		adoe <= 1'h1;
		settle();
		chk("bit15", {6'h00, pn[6], po[6]}, 8'h01);
		// core drives 0 behind a released pin; far side drives 1, the same level the floating model shows
		@(posedge clk);
		ado <= 1'h0;
		adoe <= 1'h0;
		xe <= 7'h40;
		xv <= 7'h40;
		settle();
		chk("bit15in", {6'h00, pn[6], adi}, 8'h03);
		// single-chip mode makes every pin a port
		@(posedge clk);
		ado <= 1'h0;
		adoe <= 1'h1;
		wreg(hapm_pkg::ADDR_PDIR, 8'h7F);
		wreg(hapm_pkg::ADDR_PDATA, 8'h40);
		wreg(hapm_pkg::ADDR_MODE, 8'h00);
		settle();
		chk("out", {1'h0, po}, 8'h40);
		chk("oe_n", {1'h0, pn}, 8'h00);
		rreg(hapm_pkg::ADDR_PIN, 8'h40);
		close_out();
	end
endmodule // hapm_top_tb
`default_nettype wire
